// >>> design/mefc_pkg.sv
/*
  Constants, register map and state types for the message error-reply and
  flow-control block. Assumes one clock domain and an Avalon-MM slave port.
*/
package mefc_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CMD    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_MATCH  = 4'hc;
  // Control fields
  localparam int         CTRL_RUN    = 0;
  localparam int         CTRL_SINGLE = 1;
  localparam int         CTRL_PRISUP = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h5;
  // Command fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_PRI_BIT  = 8;
  localparam int CMD_ADDR_LSB = 16;
  // Status fields; bits 1 to 3 are write-one-to-clear
  localparam int ST_CMD_PEND   = 0;
  localparam int ST_RETRY_ERR  = 1;
  localparam int ST_REJECT     = 2;
  localparam int ST_REPLY_DROP = 3;
  localparam int ST_REPLY_PEND = 4;
  localparam int ST_TAG_LSB    = 8;
  localparam int ST_COUNT_LSB  = 16;
  // Match fields
  localparam int MT_TAG_LSB  = 0;
  localparam int MT_NP       = 8;
  localparam int MT_PR       = 9;
  localparam int MT_MISS     = 10;
  localparam int MT_ADDR_LSB = 16;
  // Opcodes
  localparam logic [7:0] OP_NP_READ      = 8'h00;
  localparam logic [7:0] OP_NP_WRITE     = 8'h02;
  localparam logic [7:0] OP_NP_MREAD     = 8'h04;
  localparam logic [7:0] OP_PR_READ      = 8'h20;
  localparam logic [7:0] OP_PR_WRITE     = 8'h1e;
  localparam logic [7:0] OP_PR_PRINT     = 8'h22;
  localparam logic [7:0] OP_PR_READ_REP  = 8'h90;
  localparam logic [7:0] OP_PR_WRITE_REP = 8'h92;
  localparam logic [7:0] OP_NP_ERR_REP   = 8'ha2;
  localparam int         OP_REPLY_BIT    = 7;
  // Priority status word fields
  localparam int SW_ERR_BIT   = 15;
  localparam int SW_RUN_BIT   = 14;
  localparam int SW_CODE_LSB  = 0;
  localparam int SW_CODE_ODD  = 0;
  // Limits and codes
  localparam logic [8:0] MAX_BUSY_RETRY = 9'h100;
  localparam logic [8:0] MAX_OUTSTAND   = 9'h100;
  localparam int         PRI_DEPTH      = 4;
  localparam logic [2:0] PRI_FULL       = 3'h4;
  localparam logic [7:0] ERR_ILLEGAL_OP = 8'h01;

  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_PREP  = 2'b01,
    SRC_NPREP = 2'b10,
    SRC_CMD   = 2'b11
  } mefc_src_t;

  typedef struct packed {
    logic                       waitReq;
    logic [31:0]                rdData;
    logic                       run;
    logic                       single;
    logic                       priSup;
    logic                       cmdPend;
    logic                       cmdPri;
    logic [7:0]                 cmdOp;
    logic [15:0]                cmdAddr;
    logic [8:0]                 cmdRetry;
    logic                       prPend;
    logic [7:0]                 prOp;
    logic [15:0]                prAddr;
    logic [15:0]                prWord;
    logic                       npPend;
    logic [7:0]                 npTag;
    logic [7:0]                 npCode;
    logic [8:0]                 repRetry;
    logic                       npTurn;
    logic [7:0]                 nextTag;
    logic [255:0]               outTable;
    logic [8:0]                 outCount;
    logic [PRI_DEPTH-1:0][15:0] priQ;
    logic [2:0]                 priCnt;
    logic                       retryErr;
    logic                       reject;
    logic                       drop;
    logic [7:0]                 mTag;
    logic                       mNp;
    logic                       mPr;
    logic                       mMiss;
    logic [15:0]                mAddr;
    mefc_src_t                  src;
    logic                       txValid;
    logic                       txIsReply;
    logic [7:0]                 txOpcode;
    logic [7:0]                 txTag;
    logic [15:0]                txStatusAddr;
    logic [15:0]                txStatusWord;
    logic [7:0]                 txErrCode;
  } mefc_state_t;
endpackage : mefc_pkg

// >>> design/mefc_msg_flow.sv
/*
  Command-layer error-reply builder, transaction tagging, reply matching and
  busy retry handling. Assumes the link layer shares the clock, holds no
  done or busy pulse while txValid is low, and software uses Avalon-MM.
*/
// Overview of operation
// - Failed operations produce an error reply naming the command and a reason code.
// - Illegal or unsupported opcodes get an error reply, priority format for priority.
// - Priority error reply: opcode, two-byte status address, two-byte status word.
// - Priority error status word has bit 15 cleared.
// - Status word bit 14 shows running, clear when halted.
// - Low byte holds the error code, always odd.
// - Non-priority error reply: opcode A2, transaction tag, error code.
// - Several commands may be outstanding at once.
// - Receive and transmit paths work at the same time.
// - Busy from the link marks that specific message as failed.
// - A reply refused busy is resubmitted unchanged.
// - A command refused busy yields to ready replies, then is resent.
// - Beyond 256 busy retransmissions the message is dropped with an error.
// - Transaction tag is eight bits, 0 to 255.
// - Up to 256 outstanding commands, never two with one tag.
// - No new command starts before the link accepts or drops the previous one.
// - Tag increments after each non-priority command the link accepts.
// - Single-outstanding mode waits for the reply before the next command.
// - Non-priority replies pair with commands by tag.
// - Non-priority error replies copy the command's tag.
// - Priority replies pair by status address, oldest first.
// - Priority replies go first, non-priority ones are never starved.
module mefc_msg_flow (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxOpcode,
  input  wire logic [7:0]  rxTag,
  input  wire logic [15:0] rxStatusAddr,
  input  wire logic        rxOpOk,
  input  wire logic [7:0]  rxErrCode,
  output logic             txValid,
  output logic             txIsReply,
  output logic      [7:0]  txOpcode,
  output logic      [7:0]  txTag,
  output logic      [15:0] txStatusAddr,
  output logic      [15:0] txStatusWord,
  output logic      [7:0]  txErrCode,
  input  wire logic        txDone,
  input  wire logic        txBusy,
  output logic             retryError
);
  import mefc_pkg::*;

  mefc_state_t s;
  mefc_state_t next_s;

  // Receive decode
  logic       rxIsReply;
  logic       rxPriCmd;
  logic       rxNpCmd;
  logic       rxPriRep;
  logic       failPri;
  logic       failNp;
  logic [7:0] failCode;
  logic       cmdReady;
  logic       repLock;

  always_comb begin
    rxIsReply = rxOpcode[OP_REPLY_BIT];
    rxPriRep  = (rxOpcode == OP_PR_READ_REP) || (rxOpcode == OP_PR_WRITE_REP);
    rxPriCmd  = (rxOpcode == OP_PR_READ) || (rxOpcode == OP_PR_WRITE) ||
                (rxOpcode == OP_PR_PRINT);
    rxNpCmd   = (rxOpcode == OP_NP_READ) || (rxOpcode == OP_NP_WRITE) ||
                (rxOpcode == OP_NP_MREAD);
    failPri   = rxValid && !rxIsReply && rxPriCmd && (!s.priSup || !rxOpOk);
    failNp    = rxValid && !rxIsReply && !rxPriCmd && (!rxNpCmd || !rxOpOk);
    failCode  = (rxPriCmd && !s.priSup) || (!rxPriCmd && !rxNpCmd) ?
                ERR_ILLEGAL_OP : rxErrCode;
    // Tag collision or full table holds the command back
    cmdReady  = s.cmdPend &&
                (s.cmdPri ? (s.priCnt < PRI_FULL) :
                 (!s.outTable[s.nextTag] && (s.outCount < MAX_OUTSTAND))) &&
                (!s.single || ((s.outCount == 9'h000) && (s.priCnt == 3'h0)));
    repLock   = ((s.src == SRC_PREP) && s.prPend) || ((s.src == SRC_NPREP) && s.npPend);
  end

  always_comb begin
    logic hit;
    int   k;
    hit    = 1'b0;
    k      = 0;
    next_s = s;

    // Bus slave: one wait cycle, then a single-cycle answer
    next_s.waitReq = 1'b1;
    if ((avs_read || avs_write) && s.waitReq) begin
      next_s.waitReq = 1'b0;
      next_s.rdData  = '0;
      case (avs_address)
        REG_CTRL: begin
          next_s.rdData[CTRL_RUN]    = s.run;
          next_s.rdData[CTRL_SINGLE] = s.single;
          next_s.rdData[CTRL_PRISUP] = s.priSup;
        end
        REG_CMD: begin
          next_s.rdData[CMD_OP_LSB +: 8]    = s.cmdOp;
          next_s.rdData[CMD_PRI_BIT]        = s.cmdPri;
          next_s.rdData[CMD_ADDR_LSB +: 16] = s.cmdAddr;
        end
        REG_STATUS: begin
          next_s.rdData[ST_CMD_PEND]        = s.cmdPend;
          next_s.rdData[ST_RETRY_ERR]       = s.retryErr;
          next_s.rdData[ST_REJECT]          = s.reject;
          next_s.rdData[ST_REPLY_DROP]      = s.drop;
          next_s.rdData[ST_REPLY_PEND]      = s.prPend || s.npPend;
          next_s.rdData[ST_TAG_LSB +: 8]    = s.nextTag;
          next_s.rdData[ST_COUNT_LSB +: 9]  = s.outCount;
        end
        REG_MATCH: begin
          next_s.rdData[MT_TAG_LSB +: 8]    = s.mTag;
          next_s.rdData[MT_NP]              = s.mNp;
          next_s.rdData[MT_PR]              = s.mPr;
          next_s.rdData[MT_MISS]            = s.mMiss;
          next_s.rdData[MT_ADDR_LSB +: 16]  = s.mAddr;
        end
        default: next_s.rdData = '0;
      endcase
    end
    if (avs_write && !s.waitReq) begin
      case (avs_address)
        REG_CTRL: begin
          next_s.run    = avs_writedata[CTRL_RUN];
          next_s.single = avs_writedata[CTRL_SINGLE];
          next_s.priSup = avs_writedata[CTRL_PRISUP];
        end
        REG_CMD: begin
          // One command slot; a write while it is busy is refused
          if (s.cmdPend) begin
            next_s.reject = 1'b1;
          end else begin
            next_s.cmdPend  = 1'b1;
            next_s.cmdOp    = avs_writedata[CMD_OP_LSB +: 8];
            next_s.cmdPri   = avs_writedata[CMD_PRI_BIT];
            next_s.cmdAddr  = avs_writedata[CMD_ADDR_LSB +: 16];
            next_s.cmdRetry = '0;
          end
        end
        REG_STATUS: begin
          // Clears first so that a hardware set below wins
          if (avs_writedata[ST_RETRY_ERR]) next_s.retryErr = 1'b0;
          if (avs_writedata[ST_REJECT])    next_s.reject   = 1'b0;
          if (avs_writedata[ST_REPLY_DROP]) next_s.drop    = 1'b0;
        end
        default: ;
      endcase
    end

    // Receive path runs independently of transmit
    if (rxValid && rxIsReply) begin
      next_s.mNp   = 1'b0;
      next_s.mPr   = 1'b0;
      next_s.mMiss = 1'b0;
      if (rxPriRep) begin
        // Oldest entry sits at index 0
        for (int i = 0; i < PRI_DEPTH; i++) begin
          if (!hit && (i < int'(s.priCnt)) && (s.priQ[i] == rxStatusAddr)) begin
            hit = 1'b1;
            k   = i;
          end
        end
        if (hit) begin
          for (int i = 0; i < PRI_DEPTH - 1; i++) begin
            if (i >= k) next_s.priQ[i] = s.priQ[i+1];
          end
          next_s.priCnt = s.priCnt - 3'h1;
          next_s.mPr    = 1'b1;
          next_s.mAddr  = rxStatusAddr;
        end else begin
          next_s.mMiss  = 1'b1;
        end
      end else if (s.outTable[rxTag]) begin
        next_s.outTable[rxTag] = 1'b0;
        next_s.outCount        = s.outCount - 9'h001;
        next_s.mNp             = 1'b1;
        next_s.mTag            = rxTag;
      end else begin
        next_s.mMiss = 1'b1;
      end
    end
    // A full slot cannot take a second error reply; it is dropped and flagged
    if (failPri) begin
      if (s.prPend) begin
        next_s.drop = 1'b1;
      end else begin
        next_s.prPend = 1'b1;
        next_s.prOp   = (rxOpcode == OP_PR_READ) ? OP_PR_READ_REP : OP_PR_WRITE_REP;
        next_s.prAddr = rxStatusAddr;
        next_s.prWord = '0;
        next_s.prWord[SW_CODE_LSB +: 8] = failCode;
        next_s.prWord[SW_CODE_ODD]      = 1'b1;
        next_s.prWord[SW_RUN_BIT]       = s.run;
      end
    end
    if (failNp) begin
      if (s.npPend) begin
        next_s.drop = 1'b1;
      end else begin
        next_s.npPend = 1'b1;
        next_s.npTag  = rxTag;
        next_s.npCode = failCode;
      end
    end

    // Transmit path
    if (s.txValid) begin
      if (txDone) begin
        next_s.txValid = 1'b0;
        next_s.src     = SRC_NONE;
        case (s.src)
          SRC_PREP: begin
            next_s.prPend   = failPri && s.prPend ? 1'b0 : failPri;
            next_s.repRetry = '0;
          end
          SRC_NPREP: begin
            next_s.npPend   = failNp && s.npPend ? 1'b0 : failNp;
            next_s.repRetry = '0;
          end
          SRC_CMD: begin
            next_s.cmdPend  = 1'b0;
            next_s.cmdRetry = '0;
            if (s.cmdPri) begin
              next_s.priQ[next_s.priCnt[1:0]] = s.cmdAddr;
              next_s.priCnt = next_s.priCnt + 3'h1;
            end else begin
              next_s.outTable[s.nextTag] = 1'b1;
              next_s.outCount = next_s.outCount + 9'h001;
              next_s.nextTag  = s.nextTag + 8'h01;
            end
          end
          default: ;
        endcase
      end else if (txBusy) begin
        next_s.txValid = 1'b0;
        if (s.src == SRC_CMD) begin
          next_s.src = SRC_NONE;
          if (s.cmdRetry == MAX_BUSY_RETRY) begin
            next_s.retryErr = 1'b1;
            next_s.cmdPend  = 1'b0;
            next_s.cmdRetry = '0;
          end else begin
            next_s.cmdRetry = s.cmdRetry + 9'h001;
          end
        end else if (s.repRetry == MAX_BUSY_RETRY) begin
          next_s.retryErr = 1'b1;
          next_s.repRetry = '0;
          next_s.src      = SRC_NONE;
          // A failure in this cycle met a full slot and was dropped above
          if (s.src == SRC_PREP) next_s.prPend = 1'b0;
          else next_s.npPend = 1'b0;
        end else begin
          // Source stays locked so that the same reply goes next
          next_s.repRetry = s.repRetry + 9'h001;
        end
      end
    end else begin
      if (!repLock) begin
        next_s.src = SRC_NONE;
        // Replies always beat the command; fairness turn between replies
        if (s.prPend && (!s.npPend || !s.npTurn)) begin
          next_s.src    = SRC_PREP;
          next_s.npTurn = s.npPend;
        end else if (s.npPend) begin
          next_s.src    = SRC_NPREP;
          next_s.npTurn = 1'b0;
        end else if (cmdReady) begin
          next_s.src    = SRC_CMD;
        end
      end
      next_s.txValid = (next_s.src != SRC_NONE);
      case (next_s.src)
        SRC_PREP: begin
          next_s.txIsReply    = 1'b1;
          next_s.txOpcode     = s.prOp;
          next_s.txTag        = '0;
          next_s.txStatusAddr = s.prAddr;
          next_s.txStatusWord = s.prWord;
          next_s.txErrCode    = s.prWord[SW_CODE_LSB +: 8];
        end
        SRC_NPREP: begin
          next_s.txIsReply    = 1'b1;
          next_s.txOpcode     = OP_NP_ERR_REP;
          next_s.txTag        = s.npTag;
          next_s.txStatusAddr = '0;
          next_s.txStatusWord = '0;
          next_s.txErrCode    = s.npCode;
        end
        SRC_CMD: begin
          next_s.txIsReply    = 1'b0;
          next_s.txOpcode     = s.cmdOp;
          next_s.txTag        = s.cmdPri ? 8'h00 : s.nextTag;
          next_s.txStatusAddr = s.cmdAddr;
          next_s.txStatusWord = '0;
          next_s.txErrCode    = '0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.waitReq <= 1'b1;
      s.run     <= CTRL_RESET[CTRL_RUN];
      s.single  <= CTRL_RESET[CTRL_SINGLE];
      s.priSup  <= CTRL_RESET[CTRL_PRISUP];
      s.src     <= SRC_NONE;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata    = s.rdData;
  assign avs_waitrequest = s.waitReq;
  assign txValid         = s.txValid;
  assign txIsReply       = s.txIsReply;
  assign txOpcode        = s.txOpcode;
  assign txTag           = s.txTag;
  assign txStatusAddr    = s.txStatusAddr;
  assign txStatusWord    = s.txStatusWord;
  assign txErrCode       = s.txErrCode;
  assign retryError      = s.retryErr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_resend_gap;
    !txValid ##1 txValid;
  endsequence

  a_np_err_opcode: assert property ((s.txValid && s.src == SRC_NPREP) |->
    (txOpcode == OP_NP_ERR_REP)) else $error("np error opcode wrong");
  a_pri_err_bit15: assert property ((s.txValid && s.src == SRC_PREP) |->
    !txStatusWord[SW_ERR_BIT]) else $error("error bit not clear");
  a_pri_code_odd: assert property ((s.txValid && s.src == SRC_PREP) |->
    txStatusWord[SW_CODE_ODD]) else $error("even error code");
  a_reply_resend: assert property ((txValid && txIsReply && txBusy && !txDone &&
    s.repRetry < MAX_BUSY_RETRY) |=> s_resend_gap ##0
    (txIsReply && txOpcode == $past(txOpcode, 2))) else $error("reply not resent");
  a_cmd_yields: assert property ((txValid && s.src == SRC_CMD && txBusy && !txDone &&
    (s.prPend || s.npPend)) |=> s_resend_gap ##0 txIsReply)
    else $error("command did not yield");
  a_retry_limit: assert property ((txValid && s.src == SRC_CMD && txBusy && !txDone &&
    s.cmdRetry == MAX_BUSY_RETRY) |=> (retryError && !s.cmdPend))
    else $error("retry limit ignored");
  a_tag_step: assert property ((txValid && txDone && s.src == SRC_CMD && !s.cmdPri) |=>
    (s.nextTag == $past(s.nextTag) + 8'h01)) else $error("tag not incremented");
  a_unique_tag: assert property (($rose(txValid) && s.src == SRC_CMD && !s.cmdPri) |->
    !s.outTable[txTag]) else $error("duplicate tag sent");
  a_single_mode: assert property (($rose(txValid) && s.src == SRC_CMD && s.single) |->
    (s.outCount == 9'h000 && s.priCnt == 3'h0)) else $error("single mode broken");
  a_tag_release: assert property ((rxValid && rxIsReply && !rxPriRep &&
    s.outTable[rxTag]) |=> !s.outTable[$past(rxTag)]) else $error("entry kept");
  a_tx_hold: assert property ((txValid && !txDone && !txBusy) |=>
    (txValid && $stable(txOpcode) && $stable(txTag))) else $error("tx dropped");
  a_err_tag_copy: assert property ((failNp && !s.npPend) |=>
    (s.npPend && s.npTag == $past(rxTag))) else $error("tag not copied");
endmodule : mefc_msg_flow

// >>> dv/mefc_peer_link.sv
/*
  Link-layer model of the peer station: accepts or refuses offered messages.
  Assumes the block's clock and reset; busyN and slow come from the bench.
*/
module mefc_peer_link (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       txValid,
  input  wire logic       slow,
  input  wire logic [9:0] busyN,
  output logic            txDone,
  output logic            txBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] given;
  logic [3:0] waitCnt;
  // Answers on its own, whatever the receive side is doing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      txDone  <= 1'b0;
      txBusy  <= 1'b0;
      given   <= 10'h0;
      waitCnt <= 4'h0;
    end else begin
      txDone <= 1'b0;
      txBusy <= 1'b0;
      if (txValid && !txDone && !txBusy) begin
        if (slow && waitCnt < 4'h6) begin
          waitCnt <= waitCnt + 4'h1;
        end else begin
          waitCnt <= 4'h0;
          // Busy budget is shared by all messages offered, cleared on acceptance
          if (given < busyN) begin
            txBusy <= 1'b1;
            given  <= given + 10'h1;
          end else begin
            txDone <= 1'b1;
            given  <= 10'h0;
          end
        end
      end
    end
  end
endmodule : mefc_peer_link

// >>> dv/test_msg_error_reply_and_flow_ctl.sv
/*
  Self-checking bench for the error-reply and flow-control block.
  Assumes the peer link model and a 40 MHz clock.
*/
module test_msg_error_reply_and_flow_ctl;
  import mefc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, avs_read, avs_write, rxValid, rxOpOk, slow;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic        avs_waitrequest, txValid, txIsReply, txDone, txBusy, retryError;
  logic [7:0]  rxOpcode, rxTag, rxErrCode, txOpcode, txTag, txErrCode;
  logic [15:0] rxStatusAddr, txStatusAddr, txStatusWord;
  logic [9:0]  busyN;
  int          errTotal, totalChecks;
  wire logic [56:0] txMsg = {txIsReply, txOpcode, txTag, txStatusAddr, txStatusWord, txErrCode};
  localparam logic [56:0] MNP = {1'b1, 8'hff, 8'hff, 16'h0, 16'h0, 8'hff};
  localparam logic [56:0] MPR = {1'b1, 8'hff, 8'h0, 16'hffff, 16'hffff, 8'h0};
  localparam logic [56:0] MCM = {1'b1, 8'hff, 8'hff, 16'h0, 16'h0, 8'h0};

  mefc_msg_flow dut (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxValid(rxValid),
    .rxOpcode(rxOpcode), .rxTag(rxTag), .rxStatusAddr(rxStatusAddr), .rxOpOk(rxOpOk),
    .rxErrCode(rxErrCode), .txValid(txValid), .txIsReply(txIsReply), .txOpcode(txOpcode),
    .txTag(txTag), .txStatusAddr(txStatusAddr), .txStatusWord(txStatusWord),
    .txErrCode(txErrCode), .txDone(txDone), .txBusy(txBusy), .retryError(retryError));
  mefc_peer_link peer (.clock(clock), .rst(rst), .txValid(txValid), .slow(slow),
    .busyN(busyN), .txDone(txDone), .txBusy(txBusy));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rx(input logic [7:0] op, tg, input logic [15:0] ad, input logic ok,
                    input logic [7:0] cd);
    @(posedge clock);
    rxValid      <= 1'b1;
    rxOpcode     <= op;
    rxTag        <= tg;
    rxStatusAddr <= ad;
    rxOpOk       <= ok;
    rxErrCode    <= cd;
    @(posedge clock);
    rxValid <= 1'b0;
  endtask : rx

  // Waits for the next fresh offer, then compares the masked fields
  task automatic expTx(input logic [56:0] m, input logic [56:0] e);
    int n;
    n = 0;
    do @(posedge clock); while (txValid === 1'b1 && ++n < 400);
    do @(posedge clock); while (txValid !== 1'b1 && ++n < 800);
    check(txMsg & m, e & m);
  endtask : expTx

  function automatic logic [56:0] pk(input logic [7:0] op, tg, input logic [15:0] ad, wd,
                                     input logic [7:0] cd, input logic r = 1'b1);
    return {r, op, tg, ad, wd, cd};
  endfunction : pk

  task close_out;
    $display("checks=%0d errors=%0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    #300us;
    errTotal++;
    close_out();
  end

  initial begin
    {rst, avs_read, avs_write, rxValid, rxOpOk, slow} = 6'h20;
    {avs_address, avs_writedata, rxOpcode, rxTag, rxErrCode, rxStatusAddr} = '0;
    busyN = 10'h0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, REG_CTRL, 32'h0);
    check(q, 32'h5);
    rx(OP_NP_READ, 8'h37, 16'h0, 1'b0, 8'h0b);
    expTx(MNP, pk(OP_NP_ERR_REP, 8'h37, 16'h0, 16'h0, 8'h0b));
    // Halted, no priority support: priority command refused
    bus(1'b1, REG_CTRL, 32'h0);
    rx(OP_PR_READ, 8'h0, 16'h1234, 1'b1, 8'h0);
    expTx(MPR, pk(OP_PR_READ_REP, 8'h0, 16'h1234, 16'h0001, 8'h0));
    bus(1'b1, REG_CTRL, 32'h5);
    rx(OP_PR_WRITE, 8'h0, 16'habcd, 1'b0, 8'h0a);
    expTx(MPR, pk(OP_PR_WRITE_REP, 8'h0, 16'habcd, 16'h400b, 8'h0));
    rx(8'h44, 8'h21, 16'h0, 1'b1, 8'h0);
    expTx(MNP, pk(OP_NP_ERR_REP, 8'h21, 16'h0, 16'h0, ERR_ILLEGAL_OP));
    bus(1'b1, REG_CMD, 32'h2);
    expTx(MCM, pk(OP_NP_WRITE, 8'h0, 16'h0, 16'h0, 8'h0, 1'b0));
    bus(1'b1, REG_CMD, 32'h0);
    expTx(MCM, pk(OP_NP_READ, 8'h1, 16'h0, 16'h0, 8'h0, 1'b0));
    repeat (4) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q, 32'h00020200);
    rx(8'h86, 8'h0, 16'h0, 1'b1, 8'h0);
    bus(1'b0, REG_MATCH, 32'h0);
    check(q[10:0], 11'h100);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q[24:16], 9'h1);
    // Reply refused twice comes back unchanged
    busyN <= 10'h2;
    rx(OP_NP_WRITE, 8'h55, 16'h0, 1'b0, 8'h03);
    repeat (3) expTx(MNP, pk(OP_NP_ERR_REP, 8'h55, 16'h0, 16'h0, 8'h03));
    // Command refused while a reply waits: the reply goes first
    busyN <= 10'h1;
    slow  <= 1'b1;
    bus(1'b1, REG_CMD, {24'h0, OP_NP_MREAD});
    expTx(MCM, pk(OP_NP_MREAD, 8'h2, 16'h0, 16'h0, 8'h0, 1'b0));
    rx(OP_NP_READ, 8'h66, 16'h0, 1'b0, 8'h05);
    expTx(MNP, pk(OP_NP_ERR_REP, 8'h66, 16'h0, 16'h0, 8'h05));
    busyN <= 10'h0;
    expTx(MCM, pk(OP_NP_MREAD, 8'h2, 16'h0, 16'h0, 8'h0, 1'b0));
    // Let the resent command finish before the peer turns busy for good
    do @(posedge clock); while (txValid === 1'b1);
    // Endless busy: limit reached, a second command refused, flags cleared
    slow  <= 1'b0;
    busyN <= 10'h3ff;
    bus(1'b1, REG_CMD, 32'h0);
    bus(1'b1, REG_CMD, 32'h2);
    begin
      int n;
      n = 0;
      do @(posedge clock); while (retryError !== 1'b1 && ++n < 3000);
    end
    busyN <= 10'h0;
    check(retryError, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q[ST_RETRY_ERR], 1'b1);
    check(q[ST_REJECT], 1'b1);
    bus(1'b1, REG_STATUS, 32'h6);
    @(posedge clock);
    check(retryError, 1'b0);
    // Single mode: the command waits until both open tags are answered
    bus(1'b1, REG_CTRL, 32'h7);
    bus(1'b1, REG_CMD, 32'h2);
    repeat (4) @(posedge clock);
    bus(1'b0, REG_STATUS, 32'h0);
    check(q[ST_CMD_PEND], 1'b1);
    rx(8'h80, 8'h1, 16'h0, 1'b1, 8'h0);
    rx(8'h80, 8'h2, 16'h0, 1'b1, 8'h0);
    expTx(MCM, pk(OP_NP_WRITE, 8'h3, 16'h0, 16'h0, 8'h0, 1'b0));
    // Priority command, then its reply paired by status address
    rx(8'h80, 8'h3, 16'h0, 1'b1, 8'h0);
    bus(1'b1, REG_CMD, {16'hbeef, 7'h0, 1'b1, OP_PR_READ});
    expTx(pk(8'hff, 8'hff, 16'hffff, 16'h0, 8'h0),
          pk(OP_PR_READ, 8'h0, 16'hbeef, 16'h0, 8'h0, 1'b0));
    rx(OP_PR_READ_REP, 8'h0, 16'hbeef, 1'b1, 8'h0);
    bus(1'b0, REG_MATCH, 32'h0);
    check(q[31:8], 24'hbeef02);
    close_out();
  end
endmodule : test_msg_error_reply_and_flow_ctl
